// [hw/exc_pkg.sv]
// shared constants and types of the exception sequencer
//////////////////////////////////////////////////////////////////////////////
package exc_pkg;
   localparam logic [31:0] RESET_VEC_BASE = 32'hA0000000;
   localparam logic [31:0] VBASE_RESET    = 32'h00000000;
   localparam logic [31:0] STATUS_RESET   = 32'h000000F0;
   localparam logic [31:0] WORD_STEP      = 32'h00000004;
   localparam int          MASK_LSB       = 4;
   localparam logic [3:0]  MASK_ALL       = 4'hF;
   localparam logic [7:0]  VEC_RST_PC     = 8'h00;
   localparam logic [7:0]  VEC_RST_SP     = 8'h01;
   localparam logic [7:0]  VEC_UNDEF      = 8'h04;
   localparam logic [7:0]  VEC_SLOT       = 8'h06;
   localparam logic [7:0]  VEC_ADDR_ERR   = 8'h09;
   localparam logic [7:0]  VEC_NMI        = 8'h0B;
   localparam logic [7:0]  VEC_BREAK      = 8'h0C;
   localparam logic [7:0]  VEC_DBG_IRQ    = 8'h0D;
   localparam logic [7:0]  VEC_TRAP_BASE  = 8'h20;
   // peripheral vectors: watchdog, timer a, timer b, serial a, host
   localparam logic [39:0] VEC_PERIPH     = 40'h5455565758;
   localparam logic [19:0] PLEVEL_RESET   = 20'h00000;
   // register byte offsets on the slave bus
   localparam logic [5:0]  REG_VBASE      = 6'h00;
   localparam logic [5:0]  REG_STATUS     = 6'h04;
   localparam logic [5:0]  REG_PLEVEL     = 6'h08;
   localparam logic [5:0]  REG_STATE      = 6'h0C;

   typedef enum logic [1:0] {CLS_NONE, CLS_ADDR, CLS_IRQ, CLS_INSTR} exc_class_type;

   typedef enum {ST_IDLE, ST_RST_PC, ST_RST_SP, ST_PUSH_SR, ST_PUSH_PC, ST_FETCH}
      seq_state_type;

   // exception sources presented by the pipeline at decode
   typedef struct packed {
      logic       brk_pre;
      logic       fetch_err;
      logic       undef_op;
      logic       in_slot;
      logic       pc_change_op;
      logic       software_trap_op;
      logic [7:0] trap_imm;
      logic       data_err;
      logic       brk_post;
      logic       nmi;
      logic       dbg_irq;
      logic       ext_irq;
      logic [3:0] ext_level;
      logic [7:0] ext_vector;
      logic [4:0] periph;
   } exc_req_type;
endpackage : exc_pkg

// [hw/pin_sync.sv]
// two-stage pin synchroniser with rising-edge detect
`timescale 1ns/10ps
module pin_sync (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic pin,
   output logic      level,
   output logic      rise
);
   logic meta;
   logic prev;

   // first stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         meta  <= 1'b0;
         level <= 1'b0;
         prev  <= 1'b0;
      end else begin
         meta  <= pin;
         level <= meta;
         prev  <= level;
      end
   end

   assign rise = level & ~prev;
endmodule : pin_sync

// [hw/exc_arbiter.sv]
// fixed-priority ranking of non-reset exception sources
`timescale 1ns/10ps
module exc_arbiter (
   input  wire exc_pkg::exc_req_type   req,
   input  wire logic [3:0]             mask,
   input  wire logic [19:0]            periph_level,
   output exc_pkg::exc_class_type      cls,
   output logic [7:0]                  vector,
   output logic [3:0]                  level
);
   // highest first; maskable interrupts need level above mask
   always_comb begin
      cls    = exc_pkg::CLS_NONE;
      vector = 8'h00;
      level  = 4'h0;
      if (req.brk_pre) begin
         cls    = exc_pkg::CLS_IRQ;
         vector = exc_pkg::VEC_BREAK;
         level  = exc_pkg::MASK_ALL;
      end else if (req.fetch_err) begin
         cls    = exc_pkg::CLS_ADDR;
         vector = exc_pkg::VEC_ADDR_ERR;
      end else if (req.undef_op && !req.in_slot) begin
         cls    = exc_pkg::CLS_INSTR;
         vector = exc_pkg::VEC_UNDEF;
      end else if (req.in_slot && (req.undef_op || req.pc_change_op)) begin
         cls    = exc_pkg::CLS_INSTR;
         vector = exc_pkg::VEC_SLOT;
      end else if (req.software_trap_op) begin
         cls    = exc_pkg::CLS_INSTR;
         vector = exc_pkg::VEC_TRAP_BASE | {3'h0, req.trap_imm[4:0]};
      end else if (req.data_err) begin
         cls    = exc_pkg::CLS_ADDR;
         vector = exc_pkg::VEC_ADDR_ERR;
      end else if (req.brk_post) begin
         cls    = exc_pkg::CLS_IRQ;
         vector = exc_pkg::VEC_BREAK;
         level  = exc_pkg::MASK_ALL;
      end else if (req.nmi) begin
         cls    = exc_pkg::CLS_IRQ;
         vector = exc_pkg::VEC_NMI;
         level  = exc_pkg::MASK_ALL;
      end else if (req.dbg_irq && mask != exc_pkg::MASK_ALL) begin
         cls    = exc_pkg::CLS_IRQ;
         vector = exc_pkg::VEC_DBG_IRQ;
         level  = exc_pkg::MASK_ALL;
      end else if (req.ext_irq && req.ext_level > mask) begin
         cls    = exc_pkg::CLS_IRQ;
         vector = req.ext_vector;
         level  = req.ext_level;
      end else begin
         for (int i = 4; i >= 0; i--) begin
            if (req.periph[4 - i] && periph_level[i*4 +: 4] > mask
                && cls == exc_pkg::CLS_NONE) begin
               cls    = exc_pkg::CLS_IRQ;
               vector = exc_pkg::VEC_PERIPH[i*8 +: 8];
               level  = periph_level[i*4 +: 4];
            end
         end
      end
   end
endmodule : exc_arbiter

// [hw/cpu_exception_sequencer.sv]
// exception arbitration and entry sequencing for the core
`timescale 1ns/10ps
module cpu_exception_sequencer (
   input  wire logic                 clk_sys,
   input  wire logic                 rst_b,
   input  wire logic                 reset_pin_b,
   input  wire logic                 watchdog_overflow,
   input  wire logic                 dbg_reset_assert,
   input  wire logic                 dbg_reset_negate,
   input  wire exc_pkg::exc_req_type exc_req,
   input  wire logic                 decode_valid,
   input  wire logic                 exec_done,
   input  wire logic [31:0]          stack_gpr,
   input  wire logic [31:0]          return_pc,
   output logic                      mem_req,
   output logic                      mem_we,
   output logic [31:0]               mem_addr,
   output logic [31:0]               mem_wdata,
   input  wire logic                 mem_ack,
   input  wire logic [31:0]          mem_rdata,
   output logic                      pc_load,
   output logic [31:0]               pc_value,
   output logic                      sp_load,
   output logic [31:0]               sp_value,
   output logic                      entry_busy,
   output logic [7:0]                taken_vector,
   output logic [31:0]               status_word,
   output logic [31:0]               vector_base,
   input  wire logic [5:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   output logic [31:0]               avs_readdata,
   output logic                      avs_waitrequest
);
   ////////////////////////////////////////////////////////////////////////////
   // helpers and declarations
   function automatic logic [31:0] vec_addr(input logic [31:0] base,
                                            input logic [7:0]  vec);
      vec_addr = base + {22'h0, vec, 2'b00};
   endfunction : vec_addr

   exc_pkg::seq_state_type state;
   exc_pkg::exc_class_type arb_cls;
   exc_pkg::exc_class_type pend_cls;
   exc_pkg::exc_class_type cur_cls;
   logic [7:0]             arb_vector;
   logic [3:0]             arb_level;
   logic                   pend_valid;
   logic [7:0]             pend_vector;
   logic [3:0]             pend_level;
   logic [3:0]             cur_level;
   logic [31:0]            sp_work;
   logic [31:0]            ret_pc;
   logic [31:0]            pc_tmp;
   logic [19:0]            periph_level;
   logic                   pin_level;
   logic                   pin_rise;
   logic                   por_pend;
   logic                   dbg_armed;
   logic                   dbg_pend;
   logic                   take_reset;
   logic                   take_exc;
   logic                   bus_accept;

   ////////////////////////////////////////////////////////////////////////////
   // submodules
   pin_sync u_pin_sync (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .pin     (reset_pin_b),
      .level   (pin_level),
      .rise    (pin_rise)
   );

   exc_arbiter u_exc_arbiter (
      .req          (exc_req),
      .mask         (status_word[exc_pkg::MASK_LSB +: 4]),
      .periph_level (periph_level),
      .cls          (arb_cls),
      .vector       (arb_vector),
      .level        (arb_level)
   );

   // resets outrank everything and wait for an idle sequencer and a released (high) synchronised pin
   assign take_reset = (state == exc_pkg::ST_IDLE) && pin_level
                       && (por_pend || dbg_pend);
   assign take_exc   = (state == exc_pkg::ST_IDLE) && !take_reset && pin_level
                       && pend_valid && exec_done;
   assign bus_accept = (avs_read || avs_write) && !avs_waitrequest;

   ////////////////////////////////////////////////////////////////////////////
   // power-on request: pin release or watchdog overflow, set beats clear
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         por_pend <= 1'b0;
      end else if (pin_rise || watchdog_overflow) begin
         por_pend <= 1'b1;
      end else if (take_reset) begin
         por_pend <= 1'b0;
      end
   end

   // debug reset: assert arms, negate afterwards fires
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         dbg_armed <= 1'b0;
         dbg_pend  <= 1'b0;
      end else begin
         if (dbg_reset_assert) begin
            dbg_armed <= 1'b1;
         end else if (dbg_reset_negate) begin
            dbg_armed <= 1'b0;
         end
         if (dbg_reset_negate && dbg_armed && !dbg_reset_assert) begin
            dbg_pend <= 1'b1;
         end else if (take_reset) begin
            dbg_pend <= 1'b0;
         end
      end
   end

   // decode-time capture of the highest ranked exception
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pend_valid  <= 1'b0;
         pend_cls    <= exc_pkg::CLS_NONE;
         pend_vector <= 8'h00;
         pend_level  <= 4'h0;
      end else if (take_reset || take_exc) begin
         pend_valid <= 1'b0;
      end else if (decode_valid && !pend_valid && arb_cls != exc_pkg::CLS_NONE) begin
         pend_valid  <= 1'b1;
         pend_cls    <= arb_cls;
         pend_vector <= arb_vector;
         pend_level  <= arb_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // entry sequencer with its memory beats
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state        <= exc_pkg::ST_IDLE;
         mem_req      <= 1'b0;
         mem_we       <= 1'b0;
         mem_addr     <= 32'h00000000;
         mem_wdata    <= 32'h00000000;
         pc_load      <= 1'b0;
         pc_value     <= 32'h00000000;
         sp_load      <= 1'b0;
         sp_value     <= 32'h00000000;
         entry_busy   <= 1'b0;
         taken_vector <= 8'h00;
         cur_cls      <= exc_pkg::CLS_NONE;
         cur_level    <= 4'h0;
         sp_work      <= 32'h00000000;
         ret_pc       <= 32'h00000000;
         pc_tmp       <= 32'h00000000;
      end else begin
         pc_load <= 1'b0;
         sp_load <= 1'b0;
         case (state)
            exc_pkg::ST_IDLE: begin
               if (take_reset) begin
                  entry_busy   <= 1'b1;
                  taken_vector <= exc_pkg::VEC_RST_PC;
                  mem_req      <= 1'b1;
                  mem_we       <= 1'b0;
                  mem_addr     <= vec_addr(exc_pkg::RESET_VEC_BASE,
                                           exc_pkg::VEC_RST_PC);
                  state        <= exc_pkg::ST_RST_PC;
               end else if (take_exc) begin
                  entry_busy   <= 1'b1;
                  taken_vector <= pend_vector;
                  cur_cls      <= pend_cls;
                  cur_level    <= pend_level;
                  ret_pc       <= return_pc;
                  sp_work      <= stack_gpr - exc_pkg::WORD_STEP;
                  mem_req      <= 1'b1;
                  mem_we       <= 1'b1;
                  mem_addr     <= stack_gpr - exc_pkg::WORD_STEP;
                  mem_wdata    <= status_word;
                  state        <= exc_pkg::ST_PUSH_SR;
               end
            end
            exc_pkg::ST_RST_PC: begin
               if (mem_ack) begin
                  pc_tmp   <= mem_rdata;
                  mem_addr <= vec_addr(exc_pkg::RESET_VEC_BASE,
                                       exc_pkg::VEC_RST_SP);
                  state    <= exc_pkg::ST_RST_SP;
               end
            end
            exc_pkg::ST_RST_SP: begin
               if (mem_ack) begin
                  sp_value   <= mem_rdata;
                  sp_load    <= 1'b1;
                  pc_value   <= pc_tmp;
                  pc_load    <= 1'b1;
                  mem_req    <= 1'b0;
                  entry_busy <= 1'b0;
                  state      <= exc_pkg::ST_IDLE;
               end
            end
            exc_pkg::ST_PUSH_SR: begin
               if (mem_ack) begin
                  sp_work   <= sp_work - exc_pkg::WORD_STEP;
                  mem_addr  <= sp_work - exc_pkg::WORD_STEP;
                  mem_wdata <= ret_pc;
                  state     <= exc_pkg::ST_PUSH_PC;
               end
            end
            exc_pkg::ST_PUSH_PC: begin
               if (mem_ack) begin
                  sp_value <= sp_work;
                  sp_load  <= 1'b1;
                  mem_we   <= 1'b0;
                  mem_addr <= vec_addr(vector_base, taken_vector);
                  state    <= exc_pkg::ST_FETCH;
               end
            end
            exc_pkg::ST_FETCH: begin
               if (mem_ack) begin
                  pc_value   <= mem_rdata;
                  pc_load    <= 1'b1;
                  mem_req    <= 1'b0;
                  entry_busy <= 1'b0;
                  state      <= exc_pkg::ST_IDLE;
               end
            end
            default: begin
               state   <= exc_pkg::ST_IDLE;
               mem_req <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // vector base and status word: sequencer updates win over software
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         vector_base <= exc_pkg::VBASE_RESET;
         status_word <= exc_pkg::STATUS_RESET;
      end else if (state == exc_pkg::ST_RST_SP && mem_ack) begin
         vector_base <= exc_pkg::VBASE_RESET;
         status_word[exc_pkg::MASK_LSB +: 4] <= exc_pkg::MASK_ALL;
      end else if (state == exc_pkg::ST_PUSH_PC && mem_ack) begin
         if (cur_cls == exc_pkg::CLS_IRQ) begin
            status_word[exc_pkg::MASK_LSB +: 4] <= cur_level;
         end
         // address and instruction entries leave the mask alone
      end else if (avs_write && bus_accept && state == exc_pkg::ST_IDLE) begin
         if (avs_address == exc_pkg::REG_VBASE) begin
            vector_base <= avs_writedata;
         end else if (avs_address == exc_pkg::REG_STATUS) begin
            status_word <= avs_writedata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // slave bus: one wait cycle, then the answer
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      end
   end

   // read data, unmapped reads as zero
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && avs_waitrequest) begin
         case (avs_address)
            exc_pkg::REG_VBASE:  avs_readdata <= vector_base;
            exc_pkg::REG_STATUS: avs_readdata <= status_word;
            exc_pkg::REG_PLEVEL: avs_readdata <= {12'h000, periph_level};
            exc_pkg::REG_STATE:  avs_readdata <= {19'h00000, entry_busy, pend_valid,
                                                  por_pend, dbg_armed, dbg_pend,
                                                  taken_vector};
            default:             avs_readdata <= 32'h00000000;
         endcase
      end
   end

   // peripheral priority levels, four bits per source
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         periph_level <= exc_pkg::PLEVEL_RESET;
      end else if (avs_write && bus_accept && avs_address == exc_pkg::REG_PLEVEL) begin
         periph_level <= avs_writedata[19:0];
      end
   end
endmodule : cpu_exception_sequencer

// [verification/cpu_exception_sequencer_assertions.sv]
// concurrent checks on the exception sequencer ports
`timescale 1ns/10ps
module cpu_exception_sequencer_chk (
   input wire logic        clk_sys,
   input wire logic        rst_b,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic        mem_ack,
   input wire logic [31:0] mem_rdata,
   input wire logic        pc_load,
   input wire logic [31:0] pc_value,
   input wire logic        sp_load,
   input wire logic [31:0] sp_value,
   input wire logic        entry_busy,
   input wire logic [7:0]  taken_vector,
   input wire logic [31:0] status_word,
   input wire logic [31:0] vector_base,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   //////////////////////////////////////////////////////////////////////////
   // reset entry
   a_reset_pc_read: assert property ($rose(mem_req) && !mem_we |-> mem_addr == 32'hA0000000)
      else $error("reset entry started off the pc vector");
   a_reset_sp_read: assert property (mem_req && mem_ack && !mem_we && mem_addr == 32'hA0000000
      |=> mem_req && !mem_we && mem_addr == 32'hA0000004)
      else $error("sp vector read missing");
   a_reset_init: assert property (pc_load && sp_load
      |-> vector_base == 32'h00000000 && status_word[7:4] == 4'hF)
      else $error("vector base or mask wrong after reset entry");
   a_reset_sp_val: assert property (pc_load && sp_load |-> $past(mem_ack) && sp_value == $past(mem_rdata))
      else $error("sp not taken from vector");
   //////////////////////////////////////////////////////////////////////////
   // stacking and handler fetch
   a_handler_pc: assert property (pc_load && !sp_load
      |-> $past(mem_ack) && !$past(mem_we) && pc_value == $past(mem_rdata))
      else $error("handler pc not taken from vector read");
   a_push_step: assert property (mem_req && mem_ack && mem_we
      |=> !mem_we || mem_addr == $past(mem_addr) - 32'h00000004)
      else $error("second push not four below first");
   a_stack_drop: assert property (sp_load && !pc_load |-> $past(mem_we) && sp_value == $past(mem_addr))
      else $error("stack register not at last push");
   a_vector_addr: assert property (mem_req && mem_ack && mem_we
      |=> mem_we || mem_addr == vector_base + {22'h0, taken_vector, 2'h0})
      else $error("vector fetch address wrong");
   a_mem_in_entry: assert property (mem_req |-> entry_busy)
      else $error("memory beat outside an entry");
   a_load_pulse: assert property (pc_load |=> !pc_load)
      else $error("pc load longer than one cycle");
   //////////////////////////////////////////////////////////////////////////
   // register bus handshake
   a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   a_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer held too long");
endmodule : cpu_exception_sequencer_chk

bind cpu_exception_sequencer cpu_exception_sequencer_chk cpu_exception_sequencer_chk_i (
   .clk_sys(clk_sys), .rst_b(rst_b), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
   .mem_ack(mem_ack), .mem_rdata(mem_rdata), .pc_load(pc_load), .pc_value(pc_value),
   .sp_load(sp_load), .sp_value(sp_value), .entry_busy(entry_busy),
   .taken_vector(taken_vector), .status_word(status_word), .vector_base(vector_base),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));

// [verification/exc_mem_model.sv]
// memory partner: prompt or slow acks, reads return the inverted address
`timescale 1ns/10ps
module exc_mem_model (
   input wire logic        clk_sys,
   input wire logic        slow,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [31:0] mem_addr,
   output logic            mem_ack = 1'b0,
   output logic [31:0]     mem_rdata = 32'h00000000
);
   logic [1:0] wait_cnt = 2'h0;
   // one ack per beat; data line churns whenever no read is answered
   always_ff @(posedge clk_sys) begin
      if (!mem_req || mem_ack) begin
         mem_ack   <= 1'b0;
         wait_cnt  <= 2'h0;
         mem_rdata <= ~mem_rdata;
      end else if (wait_cnt == (slow ? 2'h3 : 2'h0)) begin
         mem_ack   <= 1'b1;
         mem_rdata <= mem_we ? ~mem_rdata : ~mem_addr;
      end else begin
         wait_cnt  <= wait_cnt + 2'h1;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule : exc_mem_model

// [verification/cpu_exception_sequencer_tb_top.sv]
// self-checking bench for the exception sequencer
`timescale 1ns/10ps
module cpu_exception_sequencer_tb_top;
   logic                 clk_sys = 1'b0, rst_b = 1'b0, reset_pin_b = 1'b0, slow = 1'b0;
   logic                 watchdog_overflow = 1'b0, dbg_reset_assert = 1'b0;
   logic                 dbg_reset_negate = 1'b0, decode_valid = 1'b0, exec_done = 1'b0;
   exc_pkg::exc_req_type exc_req = '0;
   logic [31:0]          stack_gpr = 32'h00001000, return_pc = 32'h00001234;
   logic                 mem_req, mem_we, mem_ack, pc_load, sp_load, entry_busy;
   logic [31:0]          mem_addr, mem_wdata, mem_rdata, pc_value, sp_value;
   logic [31:0]          status_word, vector_base, avs_readdata, rd;
   logic [7:0]           taken_vector;
   logic [5:0]           avs_address = 6'h00;
   logic                 avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [31:0]          avs_writedata = 32'h00000000;
   logic [31:0]          wa[$], wd[$];
   int                   error_cnt = 0, checked = 0;
   // expected {vector, mask} per case
   logic [11:0]          exp_tab [18] = '{12'h3F3, 12'h203, 12'h043, 12'h063, 12'h063,
      12'h093, 12'h093, 12'h405, 12'h0BF, 12'h0CF, 12'h093, 12'h043, 12'h3F3, 12'h093,
      12'h0CF, 12'h0BF, 12'h574, 12'h0DF};

   always #5 clk_sys = ~clk_sys;

   cpu_exception_sequencer cpu_exception_sequencer_i (.*);

   exc_mem_model exc_mem_model_i (.*);

   // log completed write beats
   always @(posedge clk_sys) begin
      if (mem_req && mem_ack && mem_we) begin
         wa.push_back(mem_addr);
         wd.push_back(mem_wdata);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // one bus access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] adr, input logic [31:0] wdat);
      int n;
      n = 0;
      avs_address   <= adr;
      avs_writedata <= wdat;
      avs_write     <= wr;
      avs_read      <= !wr;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (avs_waitrequest !== 1'b0) begin
         error_cnt++;
         close_out();
      end
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask : bus

   task automatic wait_pc();
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pc_load !== 1'b1 && n < 80);
      if (pc_load !== 1'b1) begin
         error_cnt++;
         close_out();
      end
   endtask : wait_pc

   // reset entry by pin, watchdog or debug pair, over dirty vbase and mask
   task automatic reset_entry(input int how);
      bus(1'b1, exc_pkg::REG_VBASE, 32'h00002000);
      bus(1'b1, exc_pkg::REG_STATUS, 32'h00000030);
      if (how == 2) begin
         dbg_reset_negate <= 1'b1;
         @(posedge clk_sys);
         dbg_reset_negate <= 1'b0;
         repeat (5) @(posedge clk_sys);
         cmp({31'h0, entry_busy}, 32'h0);
         dbg_reset_assert <= 1'b1;
      end
      reset_pin_b       <= 1'b1;
      watchdog_overflow <= (how == 1);
      @(posedge clk_sys);
      watchdog_overflow <= 1'b0;
      dbg_reset_assert  <= 1'b0;
      if (how == 2) begin
         repeat (3) @(posedge clk_sys);
         dbg_reset_negate <= 1'b1;
         @(posedge clk_sys);
         dbg_reset_negate <= 1'b0;
      end
      wait_pc();
      cmp({31'h0, sp_load}, 32'h1);
      cmp(pc_value, ~32'hA0000000);
      cmp(sp_value, ~32'hA0000004);
      cmp(vector_base, 32'h00000000);
      cmp({28'h0, status_word[7:4]}, 32'hF);
      @(posedge clk_sys);
      $display("reset entry %0d done", how);
   endtask : reset_entry

   function automatic exc_pkg::exc_req_type mk(input int k);
      exc_pkg::exc_req_type r;
      r = '0;
      r.trap_imm   = 8'h1F;
      r.ext_level  = 4'h5;
      r.ext_vector = 8'h40;
      case (k)
         0: r.software_trap_op = 1'b1;
         1: {r.software_trap_op, r.trap_imm} = 9'h100;
         2: r.undef_op = 1'b1;
         3: {r.undef_op, r.in_slot} = 2'h3;
         4: {r.pc_change_op, r.in_slot} = 2'h3;
         5: r.fetch_err = 1'b1;
         6: r.data_err = 1'b1;
         7: r.ext_irq = 1'b1;
         8: r.nmi = 1'b1;
         9: {r.brk_pre, r.fetch_err, r.undef_op, r.software_trap_op, r.nmi} = 5'h1F;
         10: {r.fetch_err, r.undef_op, r.software_trap_op} = 3'h7;
         11: {r.undef_op, r.software_trap_op, r.data_err} = 3'h7;
         12: {r.software_trap_op, r.data_err, r.brk_post} = 3'h7;
         13: {r.data_err, r.brk_post, r.nmi} = 3'h7;
         14: {r.brk_post, r.nmi, r.ext_irq} = 3'h7;
         15: {r.nmi, r.dbg_irq, r.ext_irq} = 3'h7;
         16: r.periph = 5'h1F;
         default: {r.dbg_irq, r.ext_irq} = 2'h3;
      endcase
      return r;
   endfunction : mk

   // one non-reset entry: decode, held-back completion, stacking, handler
   task automatic run_case(input int k);
      wa.delete();
      wd.delete();
      slow <= k[0];
      bus(1'b1, exc_pkg::REG_STATUS, 32'h00000030);
      exc_req      <= mk(k);
      decode_valid <= 1'b1;
      @(posedge clk_sys);
      decode_valid <= 1'b0;
      exc_req      <= '0;
      repeat (4) @(posedge clk_sys);
      cmp({31'h0, mem_req}, 32'h0);
      exec_done <= 1'b1;
      @(posedge clk_sys);
      exec_done <= 1'b0;
      wait_pc();
      cmp({24'h0, taken_vector}, {24'h0, exp_tab[k][11:4]});
      cmp(pc_value, ~(32'h00002000 + {22'h0, exp_tab[k][11:4], 2'h0}));
      cmp(wa[0], 32'h00000FFC);
      cmp(wd[0], 32'h00000030);
      cmp(wa[1], 32'h00000FF8);
      cmp(wd[1], 32'h00001234);
      cmp(sp_value, 32'h00000FF8);
      cmp({28'h0, status_word[7:4]}, {28'h0, exp_tab[k][3:0]});
      @(posedge clk_sys);
      $display("entry case %0d done", k);
   endtask : run_case

   //////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      cmp(status_word, 32'h000000F0);
      for (int k = 0; k < 3; k++) reset_entry(k);
      bus(1'b1, exc_pkg::REG_VBASE, 32'h00002000);
      bus(1'b0, exc_pkg::REG_VBASE, 32'h00000000);
      cmp(rd, 32'h00002000);
      bus(1'b1, 6'h10, 32'hFFFFFFFF);
      bus(1'b0, 6'h10, 32'h00000000);
      cmp(rd, 32'h00000000);
      bus(1'b1, exc_pkg::REG_PLEVEL, 32'h00012345);
      bus(1'b0, exc_pkg::REG_PLEVEL, 32'h00000000);
      cmp(rd, 32'h00012345);
      for (int k = 0; k < 18; k++) run_case(k);
      close_out();
   end
endmodule : cpu_exception_sequencer_tb_top
